// File: include/smclk_regs_defs.svh
// Purpose: Offsets, field positions, reset values and limits of the register bank
// Assumes: Included by its bare name from design files
// Notes:   Definitions only
`ifndef SMCLK_REGS_DEFS_SVH
`define SMCLK_REGS_DEFS_SVH

// Device register offsets on the link
`define POWER_RESET_OFFSET      8'h00
`define FSM_PREDIV_OFFSET       8'h02
`define CHANNEL_DIV_OFFSET      8'h03

// Device reset values
`define POWER_RESET_RESET       16'h0000
`define FSM_PREDIV_RESET        16'h0223
`define CHANNEL_DIV_RESET       16'hff86
`define POWER_RESET_AFTER_SOFT  16'h0001

// Bits that a write can change; the others read as zero
`define POWER_RESET_WMASK       16'hffff
`define FSM_PREDIV_WMASK        16'h07ff
`define CHANNEL_DIV_WMASK       16'hff87

// Field positions
`define SOFT_RESET_BIT          0
`define LOW_POWER_BIT           2
`define GEN_ON_BIT              5
`define PREDIV_LSB              6
`define PREDIV_MSB              9
`define POSTDIV_LSB             0
`define POSTDIV_MSB             2
`define CH_QUIET_LSB            7
`define CH_QUIET_MSB            10
`define LOGIC_QUIET_BIT         11
`define CH_ON_LSB               12
`define CH_ON_MSB               15

// One-hot pre-divider codes
`define PREDIV_BY2              4'h2
`define PREDIV_BY4              4'h4
`define PREDIV_BY8              4'h8

// Fields the host forces before a write
`define POWER_RESET_ZERO_MASK   16'hfffa
`define FSM_PREDIV_ZERO_MASK    16'hfc1f
`define FSM_PREDIV_FORCED       16'h0003
`define CHANNEL_DIV_ZERO_MASK   16'h0078

// Frequency limits in MHz
`define PREDIV_OUT_MAX_MHZ      32'd1600
`define FSM_CLOCK_MAX_MHZ       32'd30

// Host APB register offsets
`define HOST_CMD_OFFSET         12'h000
`define HOST_STATUS_OFFSET      12'h004
`define HOST_RDATA_OFFSET       12'h008
`define HOST_BUSY_BIT           0
`define HOST_REFUSED_BIT        1
`define HOST_CMD_WRITE_BIT      24

`endif

// File: include/smclk_regs_pkg.sv
// Purpose: Types shared by both ends of the register link
// Assumes: Nothing
// Notes:   State of each module is one packed struct
package smclk_regs_pkg;

  typedef enum logic [0:0] {
    host_idle = 1'b0,
    host_wait = 1'b1
  } host_phase_t;

  typedef struct packed {
    logic [15:0] power_and_soft_reset_control;
    logic [15:0] state_machine_clock_predivide_enable;
    logic [15:0] channel_enable_mute_and_smclk_divider;
    logic [10:0] div_count;
    logic        fsm_clock_pulse;
    logic        ack;
    logic [15:0] rdata;
    logic [3:0]  channel_output_on;
    logic        logic_output_on;
    logic        low_power_active;
  } device_state_t;

  typedef struct packed {
    host_phase_t phase;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] read_value;
    logic        refused;
    logic [3:0]  last_prediv;
    logic [2:0]  last_postdiv;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } host_state_t;

endpackage

// File: include/smclk_link_if.sv
// Purpose: Register link between the host controller and the device
// Assumes: Both ends on pclk
// Notes:   req is held until ack; ack is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface smclk_link_if;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;

  modport device (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface
`default_nettype wire

// File: design/smclk_device.sv
// Purpose: Power, soft reset and state-machine clock register bank of the device
// Assumes: pclk is the input clock; calibrating comes from logic on pclk
// Notes:   fsm_clock_pulse is one pclk wide, once per divided period
//
// What this block and the host do
// R1: Low-power bit enters low power, keeps registers
// R2: Soft reset restores device power-on state, soft reset flag left set
// R3: Soft reset bit clears on next write
// R4: Host writes zero to must-zero fields
// R5: Host writes three into low pre-divider field
// R6: Fsm clock is input divided twice
// R7: Pre-divider one-hot 2/4/8, reset 8
// R8: Host keeps pre-divider output at most 1600MHz
// R9: Fsm clock generator runs only when enabled
// R10: Host may disable generator to cut crosstalk
// R11: Cleared channel enable kills channel outputs
// R12: Mute selected outputs while calibrating
// R13: Second divider divides by two to field
// R14: Host keeps fsm clock at most 30MHz
// R15: Low power stops fsm clock and outputs
`timescale 1ns/1ns
`default_nettype none
`include "smclk_regs_defs.svh"
module smclk_device
  import smclk_regs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  smclk_link_if.device    link,
  input  wire logic       calibrating,
  output logic            fsm_clock_pulse,
  output logic [3:0]      channel_output_on,
  output logic            logic_output_on,
  output logic            low_power_active
);

  device_state_t s;
  device_state_t next_s;

  logic        take;
  logic [3:0]  prediv_code;
  logic [2:0]  postdiv_code;
  logic [10:0] prediv_factor;
  logic [10:0] div_limit;
  logic        gen_run;
  logic        low_power;
  logic [3:0]  ch_on;
  logic [3:0]  ch_quiet;
  logic [3:0]  ch_muted;

  assign take         = link.req & ~s.ack;
  assign prediv_code  = s.state_machine_clock_predivide_enable[`PREDIV_MSB:`PREDIV_LSB];
  assign postdiv_code = s.channel_enable_mute_and_smclk_divider[`POSTDIV_MSB:`POSTDIV_LSB];
  assign low_power    = s.power_and_soft_reset_control[`LOW_POWER_BIT];
  assign ch_on        = s.channel_enable_mute_and_smclk_divider[`CH_ON_MSB:`CH_ON_LSB];
  assign ch_quiet     = s.channel_enable_mute_and_smclk_divider[`CH_QUIET_MSB:`CH_QUIET_LSB];

  // Reserved pre-divider codes halt the generator
  always_comb
  begin
    case (prediv_code)
      `PREDIV_BY2: prediv_factor = 11'd2; // R7
      `PREDIV_BY4: prediv_factor = 11'd4; // R7
      `PREDIV_BY8: prediv_factor = 11'd8; // R7
      default:     prediv_factor = 11'd0;
    endcase
  end

  // Total division is pre factor times two to the post code
  assign div_limit = (prediv_factor << postdiv_code) - 11'd1; // R6 R13

  assign gen_run = s.state_machine_clock_predivide_enable[`GEN_ON_BIT] // R9
                   & ~low_power // R15
                   & (prediv_factor != 11'd0);

  // Per-channel gating during calibration
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_channel
      assign ch_muted[ch] = calibrating & ch_quiet[ch]; // R12
    end
  endgenerate

  always_comb
  begin
    next_s                 = s;
    next_s.ack             = 1'b0;
    next_s.fsm_clock_pulse = 1'b0;

    // Divided clock generator
    if (gen_run)
    begin
      if (s.div_count >= div_limit)
      begin
        next_s.div_count       = 11'd0;
        next_s.fsm_clock_pulse = 1'b1; // R6
      end
      else
      begin
        next_s.div_count = s.div_count + 11'd1;
      end
    end
    else
    begin
      next_s.div_count = 11'd0; // R9
    end

    // Outputs follow the settings held at the start of the cycle
    next_s.low_power_active  = low_power; // R1
    next_s.channel_output_on = ch_on & ~ch_muted & {4{~low_power}}; // R11 R12 R15
    next_s.logic_output_on   = ~low_power
                               & ~(calibrating
                                   & s.channel_enable_mute_and_smclk_divider[`LOGIC_QUIET_BIT]); // R12

    if (take)
    begin
      next_s.ack = 1'b1;
      if (link.we)
      begin
        // Any write first clears a pending soft reset flag
        next_s.power_and_soft_reset_control[`SOFT_RESET_BIT] = 1'b0; // R3
        case (link.addr)
          `POWER_RESET_OFFSET:
          begin
            next_s.power_and_soft_reset_control = link.wdata & `POWER_RESET_WMASK; // R1
          end
          `FSM_PREDIV_OFFSET:
          begin
            next_s.state_machine_clock_predivide_enable = link.wdata & `FSM_PREDIV_WMASK;
          end
          `CHANNEL_DIV_OFFSET:
          begin
            next_s.channel_enable_mute_and_smclk_divider = link.wdata & `CHANNEL_DIV_WMASK;
          end
          default:
          begin
            next_s.ack = 1'b1;
          end
        endcase
        if ((link.addr == `POWER_RESET_OFFSET) && link.wdata[`SOFT_RESET_BIT])
        begin
          // Same state as power-on, flag stays visible until next write
          next_s.power_and_soft_reset_control          = `POWER_RESET_AFTER_SOFT; // R2
          next_s.state_machine_clock_predivide_enable  = `FSM_PREDIV_RESET; // R2
          next_s.channel_enable_mute_and_smclk_divider = `CHANNEL_DIV_RESET; // R2
          next_s.div_count                             = 11'd0; // R2
          next_s.fsm_clock_pulse                       = 1'b0; // R2
          next_s.channel_output_on                     = 4'h0; // R2
          next_s.logic_output_on                       = 1'b0; // R2
          next_s.low_power_active                      = 1'b0; // R2
        end
      end
      else
      begin
        case (link.addr)
          `POWER_RESET_OFFSET:
          begin
            next_s.rdata = s.power_and_soft_reset_control;
          end
          `FSM_PREDIV_OFFSET:
          begin
            next_s.rdata = s.state_machine_clock_predivide_enable;
          end
          `CHANNEL_DIV_OFFSET:
          begin
            next_s.rdata = s.channel_enable_mute_and_smclk_divider;
          end
          default:
          begin
            next_s.rdata = 16'h0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.power_and_soft_reset_control          <= `POWER_RESET_RESET;
      s.state_machine_clock_predivide_enable  <= `FSM_PREDIV_RESET; // R7
      s.channel_enable_mute_and_smclk_divider <= `CHANNEL_DIV_RESET; // R13
      s.div_count                             <= 11'd0;
      s.fsm_clock_pulse                       <= 1'b0;
      s.ack                                   <= 1'b0;
      s.rdata                                 <= 16'h0000;
      s.channel_output_on                     <= 4'h0;
      s.logic_output_on                       <= 1'b0;
      s.low_power_active                      <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.ack          = s.ack;
  assign link.rdata        = s.rdata;
  assign fsm_clock_pulse   = s.fsm_clock_pulse;
  assign channel_output_on = s.channel_output_on;
  assign logic_output_on   = s.logic_output_on;
  assign low_power_active  = s.low_power_active;

endmodule
`default_nettype wire

// File: design/smclk_host.sv
// Purpose: APB-controlled host that writes and reads the device registers
// Assumes: APB on pclk; input clock frequency given as a parameter
// Notes:   Commands that would break the frequency limits are refused
`timescale 1ns/1ns
`default_nettype none
`include "smclk_regs_defs.svh"
module smclk_host
  import smclk_regs_pkg::*;
#(
  parameter int unsigned INPUT_CLOCK_MHZ = 3200
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  smclk_link_if.host       link
);

  host_state_t s;
  host_state_t next_s;

  always_comb
  begin
    logic        access;
    logic        reject;
    logic [7:0]  c_addr;
    logic [15:0] c_data;
    logic [3:0]  pre;
    logic [2:0]  post;
    logic [31:0] factor;
    access = psel & penable & ~s.pready;
    reject = 1'b0;
    c_addr = pwdata[23:16];
    c_data = pwdata[15:0];
    pre    = s.last_prediv;
    post   = s.last_postdiv;
    factor = 32'd0;

    next_s         = s;
    next_s.pready  = access;
    next_s.pslverr = 1'b0;

    // Force the must-zero and fixed fields
    case (c_addr)
      `POWER_RESET_OFFSET: c_data = c_data & ~`POWER_RESET_ZERO_MASK; // R4
      `FSM_PREDIV_OFFSET:
      begin
        c_data = (c_data & ~`FSM_PREDIV_ZERO_MASK) | `FSM_PREDIV_FORCED; // R4 R5
        pre    = c_data[`PREDIV_MSB:`PREDIV_LSB];
      end
      `CHANNEL_DIV_OFFSET:
      begin
        c_data = c_data & ~`CHANNEL_DIV_ZERO_MASK; // R4
        post   = c_data[`POSTDIV_MSB:`POSTDIV_LSB];
      end
      default: c_data = c_data;
    endcase
    case (pre)
      `PREDIV_BY2: factor = 32'd2;
      `PREDIV_BY4: factor = 32'd4;
      `PREDIV_BY8: factor = 32'd8;
      default:     factor = 32'd0;
    endcase
    if (pwdata[`HOST_CMD_WRITE_BIT]
        && ((c_addr == `FSM_PREDIV_OFFSET) || (c_addr == `CHANNEL_DIV_OFFSET)))
    begin
      reject = (factor == 32'd0)
               || (INPUT_CLOCK_MHZ > `PREDIV_OUT_MAX_MHZ * factor) // R8
               || (INPUT_CLOCK_MHZ > `FSM_CLOCK_MAX_MHZ * (factor << post)); // R14
    end

    // Link engine
    case (s.phase)
      host_idle: next_s.req = 1'b0;
      host_wait:
      begin
        if (link.ack)
        begin
          next_s.req   = 1'b0;
          next_s.phase = host_idle;
          if (!s.we)
          begin
            next_s.read_value = link.rdata;
          end
        end
      end
      default: next_s.phase = host_idle;
    endcase

    if (access)
    begin
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        `HOST_CMD_OFFSET:
        begin
          if (pwrite)
          begin
            if ((s.phase != host_idle) || reject)
            begin
              next_s.refused = 1'b1;
            end
            else
            begin
              next_s.phase = host_wait;
              next_s.req   = 1'b1;
              next_s.we    = pwdata[`HOST_CMD_WRITE_BIT];
              next_s.addr  = c_addr;
              next_s.wdata = c_data;
              if (pwdata[`HOST_CMD_WRITE_BIT])
              begin
                next_s.last_prediv  = pre;
                next_s.last_postdiv = post;
              end
            end
          end
        end
        `HOST_STATUS_OFFSET:
        begin
          if (pwrite && pwdata[`HOST_REFUSED_BIT])
          begin
            next_s.refused = 1'b0;
          end
          next_s.prdata[`HOST_BUSY_BIT]    = (s.phase != host_idle);
          next_s.prdata[`HOST_REFUSED_BIT] = s.refused;
        end
        `HOST_RDATA_OFFSET: next_s.prdata = {16'h0000, s.read_value};
        default: next_s.pslverr = 1'b1;
      endcase
      // A refusal in the clearing cycle still sets the flag
      if ((paddr == `HOST_CMD_OFFSET) && pwrite && ((s.phase != host_idle) || reject))
      begin
        next_s.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.phase        <= host_idle;
      s.req          <= 1'b0;
      s.we           <= 1'b0;
      s.addr         <= 8'h00;
      s.wdata        <= 16'h0000;
      s.read_value   <= 16'h0000;
      s.refused      <= 1'b0;
      s.last_prediv  <= `PREDIV_BY8;
      s.last_postdiv <= 3'h6;
      s.pready       <= 1'b0;
      s.pslverr      <= 1'b0;
      s.prdata       <= 32'h0000_0000;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.req   = s.req;
  assign link.we    = s.we;
  assign link.addr  = s.addr;
  assign link.wdata = s.wdata;
  assign prdata     = s.prdata;
  assign pready     = s.pready;
  assign pslverr    = s.pslverr;

endmodule
`default_nettype wire

// File: verification/smclk_link_properties.sv
// Purpose: Link, divider and output gating checks
// Assumes: One pclk domain, presetn active low
// Notes:   Instanced beside the link interface
`timescale 1ns/1ns
`default_nettype none
module smclk_link_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic        fsm_clock_pulse,
  input wire logic [3:0]  channel_output_on,
  input wire logic        logic_output_on,
  input wire logic        low_power_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ack_take: assert property (req && !ack |=> ack) else $error("ack missing");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_req_drop: assert property (ack |=> !req) else $error("req kept after ack");
  a_req_hold: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("req changed before ack");
  a_zero_fields: assert property (req && we && addr == 8'h00 |->
    (wdata & 16'hfffa) == 16'h0000) else $error("must-zero bits sent");
  a_low_field: assert property (req && we && addr == 8'h02 |->
    wdata[4:0] == 5'h03) else $error("low field not three");
  a_pulse_gap: assert property (fsm_clock_pulse |=> !fsm_clock_pulse)
    else $error("pulse too wide");
  a_lp_follow: assert property (ack && we && addr == 8'h00 && !wdata[0] |=>
    low_power_active == $past(wdata[2])) else $error("low power not taken");
  a_lp_quiet: assert property (low_power_active && $past(low_power_active) |->
    channel_output_on == 4'h0 && !logic_output_on && !fsm_clock_pulse)
    else $error("outputs active in low power");
  a_ch_gate: assert property (ack && we && addr == 8'h03 |-> ##2
    (channel_output_on & ~$past(wdata[15:12], 2)) == 4'h0)
    else $error("disabled channel on");

  c_write: cover property (ack && we);
  c_pulse: cover property (fsm_clock_pulse);
  c_low_power: cover property (low_power_active);
  c_ch_off: cover property (channel_output_on != 4'hf && !low_power_active);
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Drives the host over APB and checks both ends
// Assumes: 125 MHz pclk, INPUT_CLOCK_MHZ 3200
// Notes:   Read expectations queued, compared at pready
`timescale 1ns/1ns
`default_nettype none
`include "smclk_regs_defs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        calibrating = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fsm_clock_pulse;
  logic [3:0]  channel_output_on;
  logic        logic_output_on;
  logic        low_power_active;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [65:0] notes[$];
  logic [65:0] nt;

  always #4 pclk = ~pclk;

  smclk_link_if u_smclk_link_if ();
  smclk_host #(.INPUT_CLOCK_MHZ(3200)) u_smclk_host (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_smclk_link_if));
  smclk_device u_smclk_device (.pclk(pclk), .presetn(presetn), .link(u_smclk_link_if),
    .calibrating(calibrating), .fsm_clock_pulse(fsm_clock_pulse),
    .channel_output_on(channel_output_on), .logic_output_on(logic_output_on),
    .low_power_active(low_power_active));
  smclk_link_properties u_props (.pclk(pclk), .presetn(presetn),
    .req(u_smclk_link_if.req), .we(u_smclk_link_if.we), .addr(u_smclk_link_if.addr),
    .wdata(u_smclk_link_if.wdata), .ack(u_smclk_link_if.ack),
    .fsm_clock_pulse(fsm_clock_pulse), .channel_output_on(channel_output_on),
    .logic_output_on(logic_output_on), .low_power_active(low_power_active));

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] e, input logic [32:0] m, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w)
      notes.push_back({e, m});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, 33'h0, 33'h0, q);
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, e, m, q);
  endtask

  // Command, then poll busy
  task dev(input logic w, input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    int k;
    wr(`HOST_CMD_OFFSET, {7'h0, w, a, d});
    k = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && k < 50)
    begin
      apb(1'b0, `HOST_STATUS_OFFSET, 32'h0, 33'h0, 33'h0, q);
      k++;
    end
    // A host stuck busy is a failure, not a silent skip
    if (q[0] !== 1'b0)
    begin
      n_mismatch++;
      $display("[FAIL] host busy expected 0 seen %h", q[0]);
    end
    repeat (3) @(posedge pclk);
  endtask

  task dev_rd(input logic [7:0] a, input logic [15:0] e);
    dev(1'b0, a, 16'h0);
    rd(`HOST_RDATA_OFFSET, {17'h0, e}, 33'h1_0000_ffff);
  endtask

  // Cycles from one pulse to the next
  task per(output int n);
    int k;
    k = 0;
    while (fsm_clock_pulse !== 1'b1 && k < 2000)
    begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    n = 1;
    while (fsm_clock_pulse !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      nt = notes.pop_front();
      if (nt[32:0] != 33'h0)
        `CHK("apb read", nt[65:33] & nt[32:0], {pslverr, prdata} & nt[32:0])
    end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    logic [3:0] e;
    int n;
    void'($urandom(32'h9e6f));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    dev_rd(8'h00, 16'h0000);
    dev_rd(8'h02, 16'h0223);
    dev_rd(8'h03, 16'hff86);
    dev_rd(8'h05, 16'h0000);
    rd(12'h00c, 33'h1_0000_0000, 33'h1_0000_0000);
    `CHK("channels", 4'hf, channel_output_on)
    $display("done: reset values");
    per(n);
    per(n);
    `CHK("default period", 512, n)
    for (int i = 0; i < 3; i++)
    begin
      dev(1'b1, 8'h02, {6'h0, 4'h2 << i, 6'h23});
      per(n);
      per(n);
      `CHK("period", (2 << i) * 64, n)
    end
    dev(1'b1, 8'h03, 16'hff87);
    per(n);
    per(n);
    `CHK("period /128", 1024, n)
    dev(1'b1, 8'h02, 16'h0203);
    per(n);
    `CHK("generator off", 2000, n)
    $display("done: divider chain");
    for (int i = 0; i < 2; i++)
    begin
      dev(1'b1, i ? 8'h03 : 8'h02, i ? 16'hff80 : 16'h00e3);
      rd(`HOST_STATUS_OFFSET, 33'h2, 33'h3);
      wr(`HOST_STATUS_OFFSET, 32'h2);
    end
    rd(`HOST_STATUS_OFFSET, 33'h0, 33'h3);
    dev_rd(8'h03, 16'hff87);
    $display("done: refusals");
    repeat (4)
    begin
      e = 4'($urandom);
      dev(1'b1, 8'h03, {e, 12'hf86});
      `CHK("channel gate", e, channel_output_on)
      dev_rd(8'h03, {e, 12'hf86});
    end
    $display("done: channel enables");
    dev(1'b1, 8'h03, 16'hfc06);
    calibrating <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("muted", 5'h0e, {channel_output_on, logic_output_on})
    calibrating <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("unmuted", 5'h1f, {channel_output_on, logic_output_on})
    $display("done: mute");
    dev(1'b1, 8'h00, 16'h0004);
    `CHK("low power", 6'h20, {low_power_active, channel_output_on, logic_output_on})
    dev_rd(8'h03, 16'hfc06);
    dev(1'b1, 8'h00, 16'h0000);
    `CHK("resumed", 6'h1f, {low_power_active, channel_output_on, logic_output_on})
    $display("done: low power");
    dev(1'b1, 8'h03, 16'h0f86);
    dev(1'b1, 8'h00, 16'h0001);
    dev_rd(8'h00, 16'h0001);
    dev_rd(8'h03, 16'hff86);
    `CHK("channels after soft reset", 4'hf, channel_output_on)
    dev(1'b1, 8'h02, 16'h0223);
    dev_rd(8'h00, 16'h0000);
    per(n);
    per(n);
    `CHK("period after soft reset", 512, n)
    $display("done: soft reset");
    test_done();
  end
endmodule
`default_nettype wire
